// *** include/assr_pkg.sv ***
// Behaviour
// - During conversion, output preceding conversion's result
// - Shift MSB first, 32 clock pulses per read
// - Output bit holds across both serial clock edges
// - Pulse read overrun if a read begun during conversion is unfinished when that conversion ends
// - No chain pass-through for reads begun during conversion
// - Accept external clock, only while select low
// - Serial interface used when interface select high
// - Channel order high sends channel A first
package assr_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int CHAN_BITS  = 16;
  localparam int CNT_W      = 6;
  localparam logic [CNT_W-1:0] LAST_BIT = 6'h1f;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  ADDR_STATUS = 4'h0;
  localparam logic [3:0]  ADDR_MASK   = 4'h4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h8;
  localparam logic [3:0]  ADDR_STATE  = 4'hc;
  localparam int          EV_W        = 2;
  localparam int          EV_OVERRUN  = 0;
  localparam int          EV_DONE     = 1;
  localparam int          CTRL_EN     = 0;
  localparam logic [1:0]  STATUS_RST  = 2'h0;
  localparam logic [1:0]  MASK_RST    = 2'h0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam int          STATE_CNT_LSB  = 0;
  localparam int          STATE_FSM_LSB  = 8;
  localparam int          STATE_CONV_BIT = 12;
  localparam int          STATE_BUSY_BIT = 13;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic rd_n;
    logic chain_input;
    logic clock_source_select;
    logic interface_select;
    logic channel_order;
  } assr_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } assr_bus_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_SHIFT = 2'b01,
    S_DONE  = 2'b10
  } assr_state_t;

endpackage

// *** verilog/assr_shifter.sv ***
`timescale 1ns/1ps
module assr_shifter #(
  parameter int W = 32
) (
  input  wire logic         clk,      // System clock
  input  wire logic         rst_n,    // Synchronised reset, active low
  input  wire logic         load,     // Load a new frame
  input  wire logic [W-1:0] load_val, // Frame to send
  input  wire logic         shift,    // Advance one bit
  input  wire logic         shift_in, // Bit entering at the bottom
  output logic              msb       // Current output bit
);

  logic [W-1:0] sh_reg;
  logic [W-1:0] sh_next;

  always_comb begin
    sh_next = sh_reg;
    if (load) begin
      sh_next = load_val;
    end else if (shift) begin
      sh_next = {sh_reg[W-2:0], shift_in};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= '0;
    end else begin
      sh_reg <= sh_next;
    end
  end

  assign msb = sh_reg[W-1];

endmodule

// *** verilog/assr_top.sv ***
`timescale 1ns/1ps
module assr_top
  import assr_pkg::*;
(
  input  wire logic                   sys_clk,           // System clock, 250 MHz
  input  wire logic                   rstn,              // Async reset, active low
  input  wire assr_pkg::assr_pins_t   pins,              // Link pins, asynchronous
  input  wire logic                   conv_busy,         // Conversion in progress
  input  wire logic [15:0]            result_a,          // Channel A result, valid at busy fall
  input  wire logic [15:0]            result_b,          // Channel B result, valid at busy fall
  input  wire assr_pkg::assr_bus_t    bus,               // Register bus request
  output logic [31:0]                 rdata,             // Read data, cycle after read strobe
  output logic                        serial_out,        // Serial data out
  output logic                        serial_out_en,     // Serial output driven
  output logic                        read_overrun_flag, // Overrun pulse
  output logic                        irq                // Level interrupt
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta;
  logic       rst_n;
  assr_pins_t pin_meta;
  assr_pins_t ss;
  logic       sclk_prev;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta  <= '{sclk: 1'b0, default: 1'b1};
      ss        <= '{sclk: 1'b0, default: 1'b1};
      sclk_prev <= 1'b0;
    end else begin
      pin_meta  <= pins;
      ss        <= pin_meta;
      sclk_prev <= ss.sclk;
    end
  end

  // ----------------------------------------------------------------
  // Frame control
  // ----------------------------------------------------------------
  assr_state_t      state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             during_conv_reg, during_conv_next;
  logic             chain_reg, chain_next;
  logic [15:0]      hold_a_reg, hold_a_next;
  logic [15:0]      hold_b_reg, hold_b_next;
  logic             busy_prev_reg;
  logic [EV_W-1:0]  status_reg, status_next;
  logic [EV_W-1:0]  mask_reg, mask_next;
  logic             ctrl_en_reg, ctrl_en_next;
  logic [31:0]      rdata_next;
  logic             sel;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             conv_end;
  logic             load;
  logic             shift;
  logic             shift_in;
  logic             sh_msb;
  logic             overrun_evt;
  logic             done_evt;
  logic [31:0]      load_word;

  // The clock only counts while the chip is selected and set for slave serial mode
  assign sel = ctrl_en_reg & ss.clock_source_select & ss.interface_select
             & ~ss.cs_n & ~ss.rd_n;
  assign sclk_rise = ss.sclk & ~sclk_prev;
  assign sclk_fall = ~ss.sclk & sclk_prev;
  assign conv_end  = busy_prev_reg & ~conv_busy;
  assign load      = (state_reg == S_IDLE) && sel;
  // Bits change only after a falling edge, so each bit spans a rising and a falling edge
  assign shift     = (state_reg == S_SHIFT) && sel && sclk_fall;
  // Chain data is ignored for frames begun during conversion
  assign shift_in  = during_conv_reg ? 1'b0 : chain_reg;
  assign load_word = ss.channel_order ? {hold_a_reg, hold_b_reg}
                                      : {hold_b_reg, hold_a_reg};
  assign overrun_evt = conv_end && during_conv_reg && (state_reg == S_SHIFT);
  assign done_evt    = shift && (cnt_reg == LAST_BIT);

  always_comb begin
    state_next       = state_reg;
    cnt_next         = cnt_reg;
    during_conv_next = during_conv_reg;
    chain_next       = chain_reg;
    hold_a_next      = hold_a_reg;
    hold_b_next      = hold_b_reg;
    // Results are taken at the end of conversion, so a read during the next one sees these
    if (conv_end) begin
      hold_a_next = result_a;
      hold_b_next = result_b;
    end
    if (sclk_rise && sel) begin
      chain_next = ss.chain_input;
    end
    case (state_reg)
      S_IDLE: begin
        cnt_next = '0;
        if (sel) begin
          during_conv_next = conv_busy;
          state_next       = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (!sel) begin
          state_next = S_IDLE;
        end else if (shift) begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == LAST_BIT) begin
            state_next = S_DONE;
          end
        end
      end
      S_DONE: begin
        if (!sel) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= S_IDLE;
      cnt_reg           <= '0;
      during_conv_reg   <= 1'b0;
      chain_reg         <= 1'b0;
      hold_a_reg        <= '0;
      hold_b_reg        <= '0;
      busy_prev_reg     <= 1'b0;
      serial_out_en     <= 1'b0;
      read_overrun_flag <= 1'b0;
    end else begin
      state_reg         <= state_next;
      cnt_reg           <= cnt_next;
      during_conv_reg   <= during_conv_next;
      chain_reg         <= chain_next;
      hold_a_reg        <= hold_a_next;
      hold_b_reg        <= hold_b_next;
      busy_prev_reg     <= conv_busy;
      serial_out_en     <= sel && (state_reg != S_IDLE);
      read_overrun_flag <= overrun_evt;
    end
  end

  assr_shifter #(
    .W (FRAME_BITS)
  ) u_shifter (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .load     (load),
    .load_val (load_word),
    .shift    (shift),
    .shift_in (shift_in),
    .msb      (sh_msb)
  );

  // Straight from the shift register: one more flop would move each bit onto the next rising edge
  assign serial_out = sh_msb;

  // ----------------------------------------------------------------
  // Register file and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    status_next  = status_reg;
    mask_next    = mask_reg;
    ctrl_en_next = ctrl_en_reg;
    rdata_next   = '0;
    if (bus.wr) begin
      case (bus.addr)
        ADDR_STATUS: status_next = status_reg & ~bus.wdata[EV_W-1:0];
        ADDR_MASK:   mask_next   = bus.wdata[EV_W-1:0];
        ADDR_CTRL:   ctrl_en_next = bus.wdata[CTRL_EN];
        default:     ctrl_en_next = ctrl_en_reg;
      endcase
    end
    // A new event wins over a clear in the same cycle
    status_next[EV_OVERRUN] = status_next[EV_OVERRUN] | overrun_evt;
    status_next[EV_DONE]    = status_next[EV_DONE] | done_evt;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_STATUS: rdata_next[EV_W-1:0] = status_reg;
        ADDR_MASK:   rdata_next[EV_W-1:0] = mask_reg;
        ADDR_CTRL:   rdata_next[CTRL_EN]  = ctrl_en_reg;
        ADDR_STATE: begin
          rdata_next[STATE_CNT_LSB +: CNT_W] = cnt_reg;
          rdata_next[STATE_FSM_LSB +: 2]     = state_reg;
          rdata_next[STATE_CONV_BIT]         = during_conv_reg;
          rdata_next[STATE_BUSY_BIT]         = conv_busy;
        end
        default:     rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg  <= STATUS_RST;
      mask_reg    <= MASK_RST;
      ctrl_en_reg <= CTRL_EN_RST;
      rdata       <= '0;
      irq         <= 1'b0;
    end else begin
      status_reg  <= status_next;
      mask_reg    <= mask_next;
      ctrl_en_reg <= ctrl_en_next;
      rdata       <= rdata_next;
      irq         <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_start;
    (state_reg == S_IDLE) && sel;
  endsequence

  sequence s_conv_end;
    busy_prev_reg && !conv_busy;
  endsequence

  property p_prev_result;
    s_conv_end |=> (hold_a_reg == $past(result_a)) && (hold_b_reg == $past(result_b));
  endproperty
  a_prev_result: assert property (p_prev_result) else $error("result not held at conversion end");

  property p_msb_first;
    s_frame_start |=> sh_msb == $past(load_word[31]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the frame msb");

  property p_count_32;
    (shift && cnt_reg == LAST_BIT) |=> state_reg == S_DONE;
  endproperty
  a_count_32: assert property (p_count_32) else $error("frame did not end after 32 bits");

  property p_hold_bit;
    (state_reg == S_SHIFT && !shift) |=> $stable(sh_msb);
  endproperty
  a_hold_bit: assert property (p_hold_bit) else $error("bit changed without a falling edge");

  property p_overrun;
    (s_conv_end and (during_conv_reg && state_reg == S_SHIFT)) |=> read_overrun_flag ##1 !read_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not pulsed for one cycle");

  property p_overrun_status;
    overrun_evt |=> status_reg[EV_OVERRUN];
  endproperty
  a_overrun_status: assert property (p_overrun_status) else $error("overrun status not set");

  property p_no_chain;
    (done_evt && during_conv_reg) |=> !serial_out;
  endproperty
  a_no_chain: assert property (p_no_chain) else $error("chain bit reached output");

  property p_gated;
    (ss.cs_n || !ss.clock_source_select || !ss.interface_select) |=> state_reg == S_IDLE;
  endproperty
  a_gated: assert property (p_gated) else $error("frame active while deselected");

  property p_order;
    (s_frame_start and ss.channel_order) |=> sh_msb == $past(hold_a_reg[15]);
  endproperty
  a_order: assert property (p_order) else $error("channel A not first");

  property p_order_b;
    (s_frame_start and !ss.channel_order) |=> sh_msb == $past(hold_b_reg[15]);
  endproperty
  a_order_b: assert property (p_order_b) else $error("channel B not first");

endmodule

// *** tb/assr_host_model.sv ***
`timescale 1ns/1ps
module assr_host_model (
  input  wire logic           clk,     // Bench clock
  input  wire logic           sdo,     // Device serial output
  input  wire logic           chain,   // Chain input level
  input  wire logic           order,   // Channel order level
  input  wire logic           ext_sel, // Clock source select level
  input  wire logic           ser_sel, // Interface select level
  output assr_pkg::assr_pins_t pins    // Pins toward the device
);
  import assr_pkg::*;
  logic        sclk_q    = 1'b0;
  logic        sel_n_q   = 1'b1;
  logic [39:0] rise_bits = '0;
  logic [39:0] fall_bits = '0;
  // Clock idles low and stands still outside frames; chain held at a fixed level
  assign pins = '{sclk: sclk_q, cs_n: sel_n_q, rd_n: sel_n_q, chain_input: chain,
                  clock_source_select: ext_sel, interface_select: ser_sel, channel_order: order};
  task automatic select();
    @(posedge clk);
    sel_n_q <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  // 32 ns period plus 4 ns per gap cycle, sampled at both edges to see each bit hold across them
  task automatic pulses(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sclk_q    <= 1'b1;
      rise_bits <= {rise_bits[38:0], sdo};
      repeat (4) @(posedge clk);
      sclk_q    <= 1'b0;
      fall_bits <= {fall_bits[38:0], sdo};
      repeat (3 + gap) @(posedge clk);
    end
  endtask
  task automatic deselect();
    @(posedge clk);
    sel_n_q <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** tb/tb_adc_slave_serial_readout.sv ***
`timescale 1ns/1ps
module tb_adc_slave_serial_readout;
  import assr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        conv_busy = 1'b0;
  logic [15:0] result_a = '0;
  logic [15:0] result_b = '0;
  assr_bus_t   bus = '0;
  logic [31:0] rdata;
  logic        serial_out;
  logic        serial_out_en;
  logic        read_overrun_flag;
  logic        irq;
  logic        chain = 1'b1;
  logic        order = 1'b1;
  logic        ext_sel = 1'b1;
  logic        ser_sel = 1'b1;
  assr_pins_t  pins;
  logic [31:0] seed = 32'h6e5d;
  logic [31:0] rv;
  int          err_total = 0;
  int          num_checks = 0;
  int          ovr_cnt = 0;
  int          ovr0;
  int          ref_a = 0;
  int          ref_b = 0;

  assr_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .pins(pins), .conv_busy(conv_busy), .result_a(result_a),
    .result_b(result_b), .bus(bus), .rdata(rdata), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .read_overrun_flag(read_overrun_flag), .irq(irq));
  assr_host_model i_host (.clk(sys_clk), .sdo(serial_out), .chain(chain), .order(order), .ext_sel(ext_sel),
    .ser_sel(ser_sel), .pins(pins));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (read_overrun_flag === 1'b1) ovr_cnt++;

  // ----
  // Helpers
  // ----
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 chk("rdata", exp, rdata);
  endtask
  // Conversion ends at the busy fall; the model latches the results there
  task automatic convert(input bit fresh);
    @(posedge sys_clk);
    if (fresh) begin
      rv = seed ^ (seed << 13);
      rv = rv ^ (rv >> 17);
      seed = rv ^ (rv << 5);
      result_a <= seed[15:0];
      result_b <= seed[31:16];
    end
    conv_busy <= 1'b1;
    repeat (6) @(posedge sys_clk);
    conv_busy <= 1'b0;
    ref_a = result_a;
    ref_b = result_b;
    repeat (4) @(posedge sys_clk);
  endtask
  function automatic logic [31:0] frame(input logic o);
    return o ? {ref_a[15:0], ref_b[15:0]} : {ref_b[15:0], ref_a[15:0]};
  endfunction

  // ----
  // Sequence
  // ----
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_reg(ADDR_STATUS, 32'h0);
    chk_reg(ADDR_MASK, 32'h0);
    chk_reg(ADDR_CTRL, 32'h1);
    chk_reg(4'h2, 32'h0);
    wr(ADDR_MASK, 32'h3);
    for (int o = 0; o < 2; o++) begin
      order <= o[0];
      chain <= o[0];
      convert(1'b1);
      i_host.select();
      chk("oe", 1'b1, serial_out_en);
      i_host.pulses(16, 7);
      i_host.pulses(16, 7);
      chk("frame", frame(o[0]), i_host.rise_bits[31:0]);
      chk("frame_fall", frame(o[0]), i_host.fall_bits[31:0]);
      i_host.pulses(1, 0);
      chk("chain", o[0], i_host.rise_bits[0]);
      i_host.deselect();
      chk_reg(ADDR_STATUS, 32'h2);
      chk("irq", 1'b1, irq);
      wr(ADDR_STATUS, 32'h3);
      settle(3);
      chk("irq", 1'b0, irq);
      $display("test after_convert order %0d done", o);
    end
    convert(1'b1);
    @(posedge sys_clk);
    conv_busy <= 1'b1;
    result_a <= ~result_a;
    result_b <= ~result_b;
    ovr0 = ovr_cnt;
    i_host.select();
    i_host.pulses(33, 0);
    chk("prev", frame(order), i_host.rise_bits[32:1]);
    chk("no_chain", 1'b0, i_host.rise_bits[0]);
    i_host.deselect();
    convert(1'b0);
    chk("overrun", ovr0, ovr_cnt);
    wr(ADDR_STATUS, 32'h3);
    $display("test during_convert done");
    @(posedge sys_clk);
    conv_busy <= 1'b1;
    i_host.select();
    i_host.pulses(10, 0);
    ovr0 = ovr_cnt;
    conv_busy <= 1'b0;
    settle(6);
    chk("overrun", ovr0 + 1, ovr_cnt);
    chk("irq", 1'b1, irq);
    i_host.deselect();
    chk_reg(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h3);
    $display("test overrun done");
    ovr0 = ovr_cnt;
    convert(1'b1);
    i_host.select();
    i_host.pulses(16, 0);
    conv_busy <= 1'b1;
    i_host.pulses(16, 0);
    chk("straddle", frame(order), i_host.rise_bits[31:0]);
    i_host.deselect();
    conv_busy <= 1'b0;
    settle(4);
    chk("overrun", ovr0, ovr_cnt);
    wr(ADDR_STATUS, 32'h3);
    $display("test straddle done");
    for (int k = 0; k < 2; k++) begin
      ext_sel <= k[0];
      ser_sel <= ~k[0];
      i_host.select();
      i_host.pulses(2, 0);
      chk("oe_off", 1'b0, serial_out_en);
      i_host.deselect();
    end
    $display("test refused_select done");
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule
